// File: pkg/gpio_port_pkg.sv
// Shared constants for the six-bit general-purpose port.
package gpio_port_pkg;

    // ************************************************************
    // Widths.
    // ************************************************************
    localparam int PORT_W = 6;                // Implemented pins.
    localparam int ADDR_W = 8;                // Decoded address bits.
    localparam int DATA_W = 32;               // Bus data width.
    localparam int RSVD_BIT = 6;              // Reserved field bit.
    localparam int DEAD_BIT = 7;              // Bit with no pin behind it.

    // ************************************************************
    // Register byte offsets.
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_DATA  = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_DIR   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PULL  = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_SLEW  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_DRIVE = 8'h10;

    // ************************************************************
    // Reset values and bus answers.
    // ************************************************************
    localparam logic [PORT_W-1:0] RST_DATA  = 6'h00;
    localparam logic [PORT_W-1:0] RST_DIR   = 6'h00;
    localparam logic [PORT_W-1:0] RST_PULL  = 6'h00;
    localparam logic [PORT_W-1:0] RST_SLEW  = 6'h00;
    localparam logic [PORT_W-1:0] RST_DRIVE = 6'h00;
    localparam logic [1:0]        RESP_OKAY   = 2'h0;
    localparam logic [1:0]        RESP_SLVERR = 2'h2;

    // True when the offset names one of the five registers.
    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        return (a == OFF_DATA) || (a == OFF_DIR) || (a == OFF_PULL) ||
               (a == OFF_SLEW) || (a == OFF_DRIVE);
    endfunction

endpackage

// File: pkg/port_ctrl_if.sv
// Control bundle from the register file to the pin driver.
`timescale 1ns/1ps
interface port_ctrl_if
    import gpio_port_pkg::*;
();
    logic [PORT_W-1:0] latchBits;   // Output latch contents.
    logic [PORT_W-1:0] dirBits;     // One means output.
    logic [PORT_W-1:0] pullBits;    // Pullup requests.
    logic [PORT_W-1:0] slewBits;    // Slew limiting requests.
    logic [PORT_W-1:0] driveBits;   // High drive requests.

    // The register file owns the bundle.
    modport regs (output latchBits, dirBits, pullBits, slewBits, driveBits);

    // The pin driver only reads it.
    modport pins (input latchBits, dirBits, pullBits, slewBits, driveBits);
endinterface

// File: logic/pin_sync.sv
// Two-flop synchroniser for the pin inputs.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] metaReg;   // First stage, read only by the second.

    // Both stages clear on reset; only dout is seen by logic.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            metaReg <= '0;
            dout    <= '0;
        end else begin
            metaReg <= din;
            dout    <= metaReg;
        end
    end
endmodule

// File: logic/pin_driver.sv
// Registered pad controls for each port pin.
`timescale 1ns/1ps
module pin_driver
    import gpio_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    port_ctrl_if.pins              ctrl,
    output logic      [PORT_W-1:0] pinOut,
    output logic      [PORT_W-1:0] pinOeN,
    output logic      [PORT_W-1:0] pullupOn,
    output logic      [PORT_W-1:0] slewOn,
    output logic      [PORT_W-1:0] driveHigh
);
    // ************************************************************
    // One pad cell per pin.
    // ************************************************************
    for (genvar i = 0; i < PORT_W; i++) begin : g_pad
        // Reset leaves the pin undriven, pullup off.
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                pinOut[i]    <= 1'b0;
                pinOeN[i]    <= 1'b1;
                pullupOn[i]  <= 1'b0;
                slewOn[i]    <= 1'b0;
                driveHigh[i] <= 1'b0;
            end else begin
                pinOut[i]    <= ctrl.latchBits[i];
                pinOeN[i]    <= ~ctrl.dirBits[i];
                pullupOn[i]  <= ctrl.pullBits[i] & ~ctrl.dirBits[i];
                slewOn[i]    <= ctrl.slewBits[i] & ctrl.dirBits[i];
                driveHigh[i] <= ctrl.driveBits[i];
            end
        end
    end

    // ************************************************************
    // Checks on the pad controls.
    // ************************************************************
    a_driven_level: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> ((~pinOeN) & (pinOut ^ $past(ctrl.latchBits))) == '0)
        else $error("Driven pin differs from latch.");
    a_pullup_input: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> pullupOn == $past(ctrl.pullBits & ~ctrl.dirBits))
        else $error("Pullup does not follow its enable.");
    a_pullup_forced: assert property (@(posedge clk) disable iff (!rst_n)
        (pullupOn & ~pinOeN) == '0)
        else $error("Pullup on while pin is driven.");
    a_slew_select: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> slewOn == $past(ctrl.slewBits & ctrl.dirBits))
        else $error("Slew limit does not follow its enable.");
    a_slew_input: assert property (@(posedge clk) disable iff (!rst_n)
        (slewOn & pinOeN) == '0)
        else $error("Slew limit active on an input.");
    a_drive_select: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(ctrl.driveBits) |=> driveHigh == $past(ctrl.driveBits))
        else $error("Drive strength does not follow its select.");
endmodule

// File: logic/gpio_six_bit_port_c.sv
// Six-bit general-purpose port with an AXI4-Lite register slave.
`timescale 1ns/1ps
module gpio_six_bit_port_c
    import gpio_port_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              arst_n,
    // AXI4-Lite write address channel.
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // AXI4-Lite write data channel.
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response channel.
    output logic      [1:0]        bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address channel.
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // AXI4-Lite read data channel.
    output logic      [DATA_W-1:0] rdata,
    output logic      [1:0]        rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Port pins.
    input  wire logic [PORT_W-1:0] pinIn,
    output logic      [PORT_W-1:0] pinOut,
    output logic      [PORT_W-1:0] pinOeN,
    output logic      [PORT_W-1:0] pullupOn,
    output logic      [PORT_W-1:0] slewOn,
    output logic      [PORT_W-1:0] driveHigh
);

    // ************************************************************
    // Reset release.
    // ************************************************************

    logic rstMetaReg;   // First stage, read only by rstN.
    logic rstN;         // Synchronised reset used everywhere.

    // Reset asserts at once and releases two edges later.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rstMetaReg <= 1'b0;
            rstN       <= 1'b0;
        end else begin
            rstMetaReg <= 1'b1;
            rstN       <= rstMetaReg;
        end
    end

    // ************************************************************
    // Pin input synchronisation.
    // ************************************************************

    logic [PORT_W-1:0] pinSync;   // Pin levels in the mclk domain.

    // Pins are asynchronous to mclk, so they pass two flops.
    pin_sync #(
        .W (PORT_W)
    ) u_pin_sync (
        .clk   (mclk),
        .rst_n (rstN),
        .din   (pinIn),
        .dout  (pinSync)
    );

    // ************************************************************
    // Register storage and the pad driver.
    // ************************************************************

    port_ctrl_if ctrl ();   // Bundle to the pad driver.

    logic [PORT_W-1:0] latchReg;   // Output latch.
    logic [PORT_W-1:0] dirReg;     // Direction, one is output.
    logic [PORT_W-1:0] pullReg;    // Pullup enables.
    logic [PORT_W-1:0] slewReg;    // Slew limiting enables.
    logic [PORT_W-1:0] driveReg;   // Drive strength selects.

    // The stored fields steer the pads.
    assign ctrl.latchBits = latchReg;
    assign ctrl.dirBits   = dirReg;
    assign ctrl.pullBits  = pullReg;
    assign ctrl.slewBits  = slewReg;
    assign ctrl.driveBits = driveReg;

    // The pad controls are registered inside the driver.
    pin_driver u_pin_driver (
        .clk       (mclk),
        .rst_n     (rstN),
        .ctrl      (ctrl.pins),
        .pinOut    (pinOut),
        .pinOeN    (pinOeN),
        .pullupOn  (pullupOn),
        .slewOn    (slewOn),
        .driveHigh (driveHigh)
    );

    // ************************************************************
    // Write channels.
    // ************************************************************

    logic              awGot;        // Write address held.
    logic              wGot;         // Write data held.
    logic [ADDR_W-1:0] wrAddrHeld;   // Held write address.
    logic [PORT_W-1:0] wrDataHeld;   // Held data, pin bits only.
    logic              wrLaneHeld;   // Held strobe of byte lane 0.
    logic              awHs;         // Address handshake this edge.
    logic              wHs;          // Data handshake this edge.
    logic              wrEn;         // Both halves held: commit now.

    assign awHs = awvalid && awready;
    assign wHs  = wvalid && wready;
    assign wrEn = awGot && wGot && !bvalid;

    // Address ready drops on a take and returns when idle.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            awready <= 1'b0;
        end else begin
            awready <= !awHs && !awGot && !bvalid;
        end
    end

    // Data ready behaves the same on its own channel.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wready <= 1'b0;
        end else begin
            wready <= !wHs && !wGot && !bvalid;
        end
    end

    // The address is held until the commit.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            awGot      <= 1'b0;
            wrAddrHeld <= '0;
        end else if (awHs) begin
            awGot      <= 1'b1;
            wrAddrHeld <= awaddr;
        end else if (wrEn) begin
            awGot      <= 1'b0;
        end
    end

    // Only the pin bits are kept; bits 6 and 7 are dropped.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wGot       <= 1'b0;
            wrDataHeld <= '0;
            wrLaneHeld <= 1'b0;
        end else if (wHs) begin
            wGot       <= 1'b1;
            wrDataHeld <= wdata[PORT_W-1:0];
            wrLaneHeld <= wstrb[0];
        end else if (wrEn) begin
            wGot       <= 1'b0;
        end
    end

    // Response follows the commit; unmapped offsets get an error.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wrEn) begin
            bvalid <= 1'b1;
            bresp  <= addr_mapped(wrAddrHeld) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // True when the commit targets the given offset on lane 0.
    function automatic logic lane_write(input logic [ADDR_W-1:0] off);
        return wrEn && wrLaneHeld && (wrAddrHeld == off);
    endfunction

    // ************************************************************
    // Register fields.
    // ************************************************************

    // Latch loads all bits whatever the direction.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            latchReg <= RST_DATA;
        end else if (lane_write(OFF_DATA)) begin
            latchReg <= wrDataHeld;
        end
    end

    // Reset makes every pin an input.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            dirReg <= RST_DIR;
        end else if (lane_write(OFF_DIR)) begin
            dirReg <= wrDataHeld;
        end
    end

    // Pullups start disabled.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pullReg <= RST_PULL;
        end else if (lane_write(OFF_PULL)) begin
            pullReg <= wrDataHeld;
        end
    end

    // Slew limiting enables.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            slewReg <= RST_SLEW;
        end else if (lane_write(OFF_SLEW)) begin
            slewReg <= wrDataHeld;
        end
    end

    // Drive strength selects.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            driveReg <= RST_DRIVE;
        end else if (lane_write(OFF_DRIVE)) begin
            driveReg <= wrDataHeld;
        end
    end

    // ************************************************************
    // Read channels.
    // ************************************************************

    logic              rdEn;      // Read address taken this edge.
    logic [PORT_W-1:0] rdField;   // Pin bits of the addressed register.
    logic [DATA_W-1:0] rdWord;    // Whole word, upper bits zero.

    assign rdEn = arvalid && arready;

    // Each data bit returns the pin or the latch by direction.
    always_comb begin
        case (araddr)
            OFF_DATA:  rdField = (dirReg & latchReg) | (~dirReg & pinSync);
            OFF_DIR:   rdField = dirReg;
            OFF_PULL:  rdField = pullReg;
            OFF_SLEW:  rdField = slewReg;
            OFF_DRIVE: rdField = driveReg;
            default:   rdField = '0;
        endcase
    end

    // Bits 6 and above always read zero.
    assign rdWord = {{(DATA_W-PORT_W){1'b0}}, rdField};

    // Read ready drops on a take and returns after the answer.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            arready <= 1'b0;
        end else begin
            arready <= !rdEn && !rvalid;
        end
    end

    // Data is captured at the take and held until rready.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (rdEn) begin
            rvalid <= 1'b1;
            rdata  <= rdWord;
            rresp  <= addr_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // ************************************************************
    // Checks on the register file.
    // ************************************************************

    a_input_read: assert property (@(posedge mclk) disable iff (!rstN)
        rdEn && (araddr == OFF_DATA)
        |=> ((rdata[PORT_W-1:0] ^ $past(pinSync)) & ~$past(dirReg)) == '0)
        else $error("Input read is not the pin level.");

    a_output_read: assert property (@(posedge mclk) disable iff (!rstN)
        rdEn && (araddr == OFF_DATA)
        |=> ((rdata[PORT_W-1:0] ^ $past(latchReg)) & $past(dirReg)) == '0)
        else $error("Output read is not the latch.");

    a_latch_write: assert property (@(posedge mclk) disable iff (!rstN)
        wHs && awHs && (awaddr == OFF_DATA) && wstrb[0]
        |=> ##1 latchReg == $past(wdata[PORT_W-1:0], 2))
        else $error("Data write did not reach the latch.");

    a_reset_quiet: assert property (@(posedge mclk)
        $rose(rstN) |-> (latchReg == '0) && (pinOeN == '1) && (pullupOn == '0))
        else $error("Port not quiet after reset.");

    a_dir_select: assert property (@(posedge mclk) disable iff (!rstN)
        1'b1
        |=> pinOeN == ~$past(dirReg))
        else $error("Output enable does not follow direction.");

    a_upper_zero: assert property (@(posedge mclk) disable iff (!rstN)
        rvalid |-> rdata[DATA_W-1:PORT_W] == '0)
        else $error("Bits above the port read nonzero.");

    a_write_resp: assert property (@(posedge mclk) disable iff (!rstN)
        wrEn |=> bvalid && (bresp == (addr_mapped($past(wrAddrHeld)) ?
                                      RESP_OKAY : RESP_SLVERR)))
        else $error("Write response missing or wrong.");

    a_resp_hold: assert property (@(posedge mclk) disable iff (!rstN)
        bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped before bready.");

endmodule

// File: dv/ext_pins.sv
// Behavioural model of the circuitry that sits on the six port pins.
`timescale 1ns/1ps
module ext_pins
    import gpio_port_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [PORT_W-1:0] pinOut,
    input  wire logic [PORT_W-1:0] pinOeN,
    input  wire logic [PORT_W-1:0] pullupOn,
    input  wire logic [PORT_W-1:0] extEn,
    input  wire logic [PORT_W-1:0] extVal,
    output logic      [PORT_W-1:0] pinLevel
);
    // ************************************************************
    // Wire resolution.
    // ************************************************************
    logic [PORT_W-1:0] floatPat;   // Level of a pin that nobody holds.

    // A floating pin wanders every cycle so that a stale value cannot pass.
    initial floatPat = 6'h15;
    always @(posedge clk) begin
        floatPat <= ~floatPat;
    end

    // The device driver wins, then the outside driver, then the pullup.
    always_comb begin
        for (int i = 0; i < PORT_W; i++) begin
            if (!pinOeN[i]) begin
                pinLevel[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinLevel[i] = extVal[i];
            end else if (pullupOn[i]) begin
                pinLevel[i] = 1'b1;
            end else begin
                pinLevel[i] = floatPat[i];
            end
        end
    end
endmodule

// File: dv/tb.sv
// Self-checking testbench for the six-bit port.
`timescale 1ns/1ps
module tb
    import gpio_port_pkg::*;
;
    // ************************************************************
    // Signals.
    // ************************************************************
    logic              mclk, arst_n;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [1:0]        bresp, rresp;
    logic [PORT_W-1:0] pinLevel, pinOut, pinOeN, pullupOn, slewOn, driveHigh;
    logic [PORT_W-1:0] extEn, extVal;           // Outside drivers.
    int                failCount, nTests, seedVal;
    logic [5:0]        mdl [5];                 // Model registers.
    logic [ADDR_W-1:0] offs [5] = '{OFF_DATA, OFF_DIR, OFF_PULL, OFF_SLEW, OFF_DRIVE};

    gpio_six_bit_port_c u_dut (.mclk(mclk), .arst_n(arst_n), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pinIn(pinLevel), .pinOut(pinOut), .pinOeN(pinOeN), .pullupOn(pullupOn),
        .slewOn(slewOn), .driveHigh(driveHigh));

    ext_pins u_ext (.clk(mclk), .pinOut(pinOut), .pinOeN(pinOeN), .pullupOn(pullupOn),
        .extEn(extEn), .extVal(extVal), .pinLevel(pinLevel));

    // The clock runs at 50 MHz.
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ************************************************************
    // Reporting.
    // ************************************************************
    // Prints the verdict and stops the run.
    task automatic endOfTest;
        if (failCount == 0 && nTests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Counts a hang as a mismatch and closes the run.
    task automatic hang(input int n);
        if (n > 200) begin
            failCount++;
            $display("mismatch at %0t: bus answer never came", $time);
            endOfTest();
        end
    endtask

    // Compares a value under a mask of the bits whose outcome is known.
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp,
                           input logic [31:0] msk);
        nTests++;
        if ((got & msk) !== (exp & msk)) begin
            failCount++;
            $display("mismatch at %0t: value %h expected %h", $time, got, exp);
        end
    endtask

    // Compares a bus response code.
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        nTests++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t: response %h expected %h", $time, got, exp);
        end
    endtask

    // ************************************************************
    // Bus master tasks.
    // ************************************************************
    // One write; address and data are released as each is taken.
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, output logic [1:0] r);
        int  n;
        logic ad, wd;
        n = 0;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge mclk);
            if (!ad && awready === 1'b1) begin
                ad = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wd && wready === 1'b1) begin
                wd = 1'b1;
                wvalid <= 1'b0;
            end
            hang(++n);
        end
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            hang(++n);
        end while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    // One read; rready is held up until the answer is seen.
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            hang(++n);
        end while (arready !== 1'b1);
        arvalid <= 1'b0;
        do begin
            @(posedge mclk);
            hang(++n);
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    // ************************************************************
    // Checks against the model.
    // ************************************************************
    // Checks pads and reads every register back.
    task automatic check_all;
        logic [5:0]  dir, pull, dexp, dmsk;
        logic [31:0] d;
        logic [1:0]  r;
        dir = mdl[1];
        pull = mdl[2] & ~dir & ~extEn;
        chk_val(32'(pinOeN), 32'(~dir), 32'h3f);
        chk_val(32'(pinOut), 32'(mdl[0]), 32'(dir));
        chk_val(32'(pullupOn), 32'(mdl[2] & ~dir), 32'h3f);
        chk_val(32'(slewOn), 32'(mdl[3] & dir), 32'h3f);
        chk_val(32'(driveHigh), 32'(mdl[4]), 32'h3f);
        dexp = (mdl[0] & dir) | (extVal & extEn) | pull;
        dmsk = dir | extEn | pull;
        for (int i = 0; i < 5; i++) begin
            axi_rd(offs[i], d, r);
            chk_resp(r, RESP_OKAY);
            if (i == 0) begin
                chk_val(d, 32'(dexp), {26'h3ffffff, dmsk});
            end else begin
                chk_val(d, 32'(mdl[i]), 32'hffffffff);
            end
        end
    endtask

    // ************************************************************
    // Main sequence.
    // ************************************************************
    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        {awaddr, araddr, wdata, wstrb, extEn, extVal} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        failCount = 0;
        nTests = 0;
        arst_n = 1'b0;
        for (int i = 0; i < 5; i++) mdl[i] = 6'h00;
        seedVal = $urandom(32'h9e0a);
        repeat (8) @(posedge mclk);
        arst_n <= 1'b1;
        check_all();
        // Random settings; data goes first, so inputs keep a latch too.
        for (int it = 0; it < 40; it++) begin
            for (int i = 0; i < 5; i++) begin
                v = $urandom;
                v[RSVD_BIT] = 1'b0;
                axi_wr(offs[i], v, 4'hf, r);
                chk_resp(r, RESP_OKAY);
                mdl[i] = v[5:0];
            end
            extEn <= 6'($urandom) & ~mdl[1];
            extVal <= 6'($urandom);
            repeat (4) @(posedge mclk);
            check_all();
        end
        // Every pin an output, then every pin an input held from outside.
        for (int k = 0; k < 2; k++) begin
            axi_wr(OFF_DIR, (k == 0) ? 32'h3f : 32'h0, 4'hf, r);
            chk_resp(r, RESP_OKAY);
            mdl[1] = (k == 0) ? 6'h3f : 6'h00;
            extEn <= (k == 0) ? 6'h00 : 6'h3f;
            extVal <= 6'($urandom);
            repeat (4) @(posedge mclk);
            check_all();
        end
        // Unmapped places answer with an error and store nothing.
        axi_wr(8'h14, 32'h3f, 4'hf, r);
        chk_resp(r, RESP_SLVERR);
        axi_rd(8'hfc, v, r);
        chk_resp(r, RESP_SLVERR);
        chk_val(v, 32'h0, 32'hffffffff);
        // A write with its low byte disabled changes nothing.
        axi_wr(OFF_DIR, 32'h3f, 4'h0, r);
        chk_resp(r, RESP_OKAY);
        check_all();
        // A reset in mid-run returns everything to inputs with latches clear.
        @(posedge mclk);
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        for (int i = 0; i < 5; i++) mdl[i] = 6'h00;
        repeat (4) @(posedge mclk);
        check_all();
        endOfTest();
    end
endmodule
